// >>> rtl/cec_pkg.sv
package cec_pkg;
  // register map, one aligned word each
  localparam logic [11:0] CEC_CTRL_OFS     = 12'h000;
  localparam logic [11:0] CEC_STATUS_OFS   = 12'h004;
  localparam logic [11:0] CEC_ROUTE_OFS    = 12'h008;
  // control field positions
  localparam int CEC_RISE_BIT  = 7;
  localparam int CEC_FALL_BIT  = 6;
  localparam int CEC_PSEL_HI   = 5;
  localparam int CEC_PSEL_LO   = 4;
  localparam int CEC_NSEL_HI   = 1;
  localparam int CEC_NSEL_LO   = 0;
  // status field positions
  localparam int CEC_FLAG_BIT  = 0;
  localparam int CEC_RES_BIT   = 1;
  // writable bits of the control register (bits 3 and 2 unimplemented)
  localparam logic [7:0] CEC_CTRL_MASK  = 8'hF3;
  localparam logic [7:0] CEC_CTRL_RESET = 8'h00;
  // positive input codes
  localparam logic [1:0] CEC_P_PIN   = 2'h0;
  localparam logic [1:0] CEC_P_DAC   = 2'h1;
  localparam logic [1:0] CEC_P_FIXREF = 2'h2;
  // one-hot route selects
  localparam logic [2:0] CEC_PROUTE_NONE = 3'h0;
endpackage

// >>> rtl/cec_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
// compares current and previous samples of the comparator result
module cec_edge_detect
  import cec_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sample,
  output logic      rise,
  output logic      fall,
  output logic      level
);
  logic prev_q;
  logic prev_d;
  logic cur_q;
  logic cur_d;

  // next sample values
  always_comb begin
    cur_d  = sample;
    prev_d = cur_q;
  end

  // sample registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q  <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      cur_q  <= cur_d;
      prev_q <= prev_d;
    end
  end

  // edges from current versus previous sample
  assign rise  = cur_q & ~prev_q; // R8
  assign fall  = ~cur_q & prev_q; // R8
  assign level = cur_q;
endmodule
`default_nettype wire

// >>> rtl/cec_top.sv
// Overview of operation
// (R1) rise enable set: rising result edge sets flag
// (R2) rise enable clear: rising edge ignored
// (R3) fall enable gates flag on falling edges
// (R4) positive select: pin, dac, fixed reference
// (R5) large variant: two-bit negative select, pins 0-3
// (R6) small variant: one-bit negative select, pins 0-1
// (R7) bits 3 and 2 read as zero
// (R8) flag sticky until cleared; sampled edge detect
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cec_top
  import cec_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        COMPARATOR_RESULT_BIT,
  output logic             COMPARATOR_EVENT_FLAG,
  output logic      [2:0]  NONINVERTING_INPUT_NODE,
  output logic      [3:0]  INVERTING_INPUT_NODE
);
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        flag_q;
  logic        flag_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [2:0]  proute_q;
  logic [2:0]  proute_d;
  logic [3:0]  nroute_q;
  logic [3:0]  nroute_d;
  logic        rise;
  logic        fall;
  logic        level;
  logic        wr_en;
  logic        rd_en;
  logic        hit;

  // decode of a register offset
  function automatic logic known_ofs(input logic [11:0] a);
    known_ofs = (a == CEC_CTRL_OFS) || (a == CEC_STATUS_OFS) || (a == CEC_ROUTE_OFS);
  endfunction

  // edge detector on the comparator result
  cec_edge_detect u_edge (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .sample (COMPARATOR_RESULT_BIT),
    .rise   (rise),
    .fall   (fall),
    .level  (level)
  );

  // apb handshake: zero wait, error on unmapped offsets
  assign hit     = known_ofs(PADDR);
  assign wr_en   = PSEL & PENABLE & PWRITE & hit;
  assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;

  // control register, flag and read data next values
  always_comb begin
    ctrl_d  = ctrl_q;
    flag_d  = flag_q;
    rdata_d = rdata_q;
    if (wr_en && PADDR == CEC_CTRL_OFS && PSTRB[0]) begin
      ctrl_d = PWDATA[7:0] & CEC_CTRL_MASK; // R7
    end
    // write one to clear the flag
    if (wr_en && PADDR == CEC_STATUS_OFS && PSTRB[0] && PWDATA[CEC_FLAG_BIT]) begin
      flag_d = 1'b0;
    end
    // a set in the same cycle wins over the clear
    if (rise && ctrl_q[CEC_RISE_BIT]) begin
      flag_d = 1'b1; // R1 R2 R8
    end
    if (fall && ctrl_q[CEC_FALL_BIT]) begin
      flag_d = 1'b1; // R3 R8
    end
    if (rd_en) begin
      rdata_d = 32'h0000_0000;
      unique case (PADDR)
        CEC_CTRL_OFS: begin
          rdata_d[7:0] = ctrl_q & CEC_CTRL_MASK; // R7
        end
        CEC_STATUS_OFS: begin
          rdata_d[CEC_FLAG_BIT] = flag_q;
          rdata_d[CEC_RES_BIT]  = level;
        end
        CEC_ROUTE_OFS: begin
          rdata_d[2:0] = proute_q;
          rdata_d[7:4] = nroute_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // input routing as one-hot selects
  always_comb begin
    proute_d = CEC_PROUTE_NONE;
    unique case (ctrl_q[CEC_PSEL_HI:CEC_PSEL_LO])
      CEC_P_PIN: proute_d = 3'h1; // R4
      CEC_P_DAC: proute_d = 3'h2; // R4
      CEC_P_FIXREF: proute_d = 3'h4; // R4
      default:   proute_d = CEC_PROUTE_NONE;
    endcase
    nroute_d = 4'h0;
    if (LARGE_VARIANT) begin
      nroute_d[ctrl_q[CEC_NSEL_HI:CEC_NSEL_LO]] = 1'b1; // R5
    end else begin
      nroute_d[{1'b0, ctrl_q[CEC_NSEL_LO]}] = 1'b1; // R6
    end
  end

  // state registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q   <= CEC_CTRL_RESET;
      flag_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      proute_q <= 3'h1;
      nroute_q <= 4'h1;
    end else begin
      ctrl_q   <= ctrl_d;
      flag_q   <= flag_d;
      rdata_q  <= rdata_d;
      proute_q <= proute_d;
      nroute_q <= nroute_d;
    end
  end

  assign PRDATA                  = rdata_q;
  assign COMPARATOR_EVENT_FLAG   = flag_q;
  assign NONINVERTING_INPUT_NODE = proute_q;
  assign INVERTING_INPUT_NODE    = nroute_q;
endmodule
`default_nettype wire

// >>> dv/cec_props.sv
`timescale 1ns/10ps
`default_nettype none
// watches flag causes, readback and input routing
module cec_props
  import cec_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        COMPARATOR_RESULT_BIT,
  input wire logic        COMPARATOR_EVENT_FLAG,
  input wire logic [2:0]  NONINVERTING_INPUT_NODE,
  input wire logic [3:0]  INVERTING_INPUT_NODE
);
  logic [7:0] ctl_q;
  logic       r, f, wr, clr;
  // shorthands and a mirror of the control register
  assign r = COMPARATOR_RESULT_BIT;
  assign f = COMPARATOR_EVENT_FLAG;
  assign wr = PSEL & PENABLE & PWRITE;
  assign clr = wr & (PADDR == CEC_STATUS_OFS) & PWDATA[0];
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) ctl_q <= 8'h00;
    else if (wr && PADDR == CEC_CTRL_OFS) ctl_q <= PWDATA[7:0];
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_rise_sets:
    assert property ($rose(r) && ctl_q[7] |-> ##2 f) else $error("rise lost");
  chk_fall_sets:
    assert property ($fell(r) && ctl_q[6] |-> ##2 f) else $error("fall lost");
  chk_flag_cause:
    assert property ($rose(f) |-> $past(r, 2) != $past(r, 3) && ($past(r, 2) ? $past(ctl_q[7]) : $past(ctl_q[6])))
    else $error("flag without cause");
  chk_flag_sticky:
    assert property (f && !clr |=> f) else $error("flag dropped");
  chk_flag_clear:
    assert property (clr && $past(r) == $past(r, 2) |=> !f) else $error("flag kept");
  chk_pos_route:
    assert property (NONINVERTING_INPUT_NODE == ($past(ctl_q[5:4]) == 2'h3 ? 3'h0 : 3'h1 << $past(ctl_q[5:4])))
    else $error("pos route");
  chk_neg_route:
    assert property (INVERTING_INPUT_NODE == 4'h1 << $past(ctl_q[1:0])) else $error("neg route");
  chk_ctrl_read:
    assert property (PSEL && PENABLE && !PWRITE && PADDR == CEC_CTRL_OFS |-> PRDATA == {24'h0, ctl_q & 8'hF3})
    else $error("ctrl read");
endmodule
bind cec_top cec_props u_props (.*);
`default_nettype wire

// >>> dv/cec_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cec_top_tb import cec_pkg::*;;
  logic        MCLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, COMPARATOR_RESULT_BIT = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, q;
  logic [3:0]  PSTRB = 4'h1, INVERTING_INPUT_NODE;
  logic [2:0]  NONINVERTING_INPUT_NODE;
  logic        PREADY, PSLVERR, COMPARATOR_EVENT_FLAG, e;
  logic [9:0]  stp [6] = '{10'h203, 10'h200, 10'h102, 10'h101, 10'h303, 10'h301};
  int          n_fail = 0, cmp_count = 0;
  cec_top dut (.*);
  // 20 MHz clock
  always #25 MCLK = ~MCLK;
  task automatic chk(input string n, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer, then an idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK) PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic conclude;
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // routing codes, then edge steps {ctrl, level, flag}
  initial begin
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, CEC_CTRL_OFS, i * 32'h0000_0011 | 32'h0000_000C);
      xfer(1'b0, CEC_CTRL_OFS, 32'h0);
      chk("ctrl", q, i * 32'h0000_0011);
      chk("pos", NONINVERTING_INPUT_NODE, i == 3 ? 0 : 1 << i);
      chk("neg", INVERTING_INPUT_NODE, 1 << i);
      xfer(1'b0, CEC_ROUTE_OFS, 32'h0);
      chk("route", q, ((32'h0000_0001 << i) << 4) | (i == 3 ? 32'h0000_0000 : 32'h0000_0001 << i));
      chk("okay", e, 0);
    end
    foreach (stp[j]) begin
      xfer(1'b1, CEC_CTRL_OFS, {24'h0, stp[j][9:2]});
      COMPARATOR_RESULT_BIT <= stp[j][1];
      repeat (4) @(posedge MCLK);
      chk("flag", COMPARATOR_EVENT_FLAG, stp[j][0]);
      xfer(1'b0, CEC_STATUS_OFS, 32'h0);
      chk("status", q, {30'h0, stp[j][1], stp[j][0]});
      xfer(1'b1, CEC_STATUS_OFS, 32'h0000_0001);
      chk("clear", COMPARATOR_EVENT_FLAG, 0);
    end
    xfer(1'b0, 12'h00C, 32'h0);
    chk("err", e, 1);
    conclude();
  end
  // stop a hung run
  initial begin
    #50us;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
